// [hw/adgc_pkg.sv]
package adgc_pkg;

  // ==========================================================================
  // Register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] OFF_GENERAL_CONTROL = 4'h3;
  localparam logic [3:0] OFF_ANALOG_PIN_SEL  = 4'h4;

  // ==========================================================================
  // General control field positions
  localparam int unsigned BIT_BUFFER_PRECHARGE = 9;
  localparam int unsigned BIT_BUFFER_ENABLE    = 8;
  localparam int unsigned BIT_CONFIG_LOCK      = 7;
  localparam int unsigned BIT_BROADCAST_DAC    = 6;
  localparam int unsigned BIT_ADC_RANGE        = 5;
  localparam int unsigned BIT_DAC_RANGE        = 4;

  // ==========================================================================
  // Analog input pin select layout
  localparam int unsigned PIN_COUNT    = 8;
  localparam int unsigned PIN_SEL_LSB  = 0;
  localparam int unsigned DAC_CH_W     = 3;
  localparam int unsigned DAC_DATA_W   = 12;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] RST_GENERAL_CONTROL = 16'h0000;
  localparam logic [15:0] RST_ANALOG_PIN_SEL  = 16'h0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic buffer_precharge;
    logic buffer_enable;
    logic config_lock;
    logic broadcast_dac;
    logic adc_range;
    logic dac_range;
  } adgc_ctrl_t;

  typedef struct packed {
    logic                  valid;
    logic [DAC_CH_W-1:0]   channel;
    logic [DAC_DATA_W-1:0] data;
  } adgc_dac_req_t;

endpackage

// [hw/adgc_regs.sv]
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module adgc_regs
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Register port
  input  wire logic [adgc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [adgc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [adgc_pkg::DATA_W-1:0]   reg_rdata,
  // Converter status
  input  wire logic                          conv_active,
  // DAC write request and DAC pin map
  input  wire adgc_pkg::adgc_dac_req_t       dac_req,
  input  wire logic [adgc_pkg::PIN_COUNT-1:0] dac_pins,
  // DAC channel loads
  output logic      [adgc_pkg::PIN_COUNT-1:0] dac_load,
  output logic      [adgc_pkg::DAC_DATA_W-1:0] dac_load_data,
  // Analog controls
  output logic                               buf_power,
  output logic                               buf_precharge_use,
  output logic                               adc_range_2x,
  output logic                               dac_range_2x,
  // Pin configuration
  output logic                               pin_config_lock,
  output logic      [adgc_pkg::PIN_COUNT-1:0] analog_input_pins,
  output logic      [adgc_pkg::PIN_COUNT-1:0] pin_other_config
);

  // ==========================================================================
  // Address decode

  function automatic logic addr_hit
  (
    input logic [adgc_pkg::ADDR_W-1:0] addr,
    input logic [adgc_pkg::ADDR_W-1:0] off
  );
    addr_hit = (addr == off);
  endfunction

  adgc_pkg::adgc_ctrl_t               ctrl;
  logic [adgc_pkg::PIN_COUNT-1:0]     pin_sel;
  adgc_pkg::adgc_ctrl_t               next_ctrl;
  logic [adgc_pkg::PIN_COUNT-1:0]     next_pin_sel;
  logic [adgc_pkg::DATA_W-1:0]        ctrl_word;
  logic [adgc_pkg::DATA_W-1:0]        pin_word;
  logic [adgc_pkg::DATA_W-1:0]        rsel_word;
  logic [adgc_pkg::DATA_W-1:0]        next_rdata;
  wire                                hit_ctrl;
  wire                                hit_pins;
  wire                                wr_ctrl;
  wire                                wr_pins;

  assign hit_ctrl = addr_hit(reg_addr, adgc_pkg::OFF_GENERAL_CONTROL);
  assign hit_pins = addr_hit(reg_addr, adgc_pkg::OFF_ANALOG_PIN_SEL);
  assign wr_ctrl  = reg_wr && hit_ctrl;
  // The lock in force before this write decides; it lives in another register.
  assign wr_pins  = reg_wr && hit_pins && !ctrl.config_lock;

  // ==========================================================================
  // Register update

  // One driver for the whole struct keeps strict tools from seeing several.
  assign next_ctrl = '{
    buffer_precharge: reg_wdata[adgc_pkg::BIT_BUFFER_PRECHARGE],
    buffer_enable:    reg_wdata[adgc_pkg::BIT_BUFFER_ENABLE],
    config_lock:      reg_wdata[adgc_pkg::BIT_CONFIG_LOCK],
    broadcast_dac:    reg_wdata[adgc_pkg::BIT_BROADCAST_DAC],
    adc_range:        reg_wdata[adgc_pkg::BIT_ADC_RANGE],
    dac_range:        reg_wdata[adgc_pkg::BIT_DAC_RANGE]
  };
  assign next_pin_sel = reg_wdata[adgc_pkg::PIN_SEL_LSB +: adgc_pkg::PIN_COUNT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= '0;
    end
    else if (wr_ctrl)
    begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sel <= adgc_pkg::RST_ANALOG_PIN_SEL[adgc_pkg::PIN_COUNT-1:0];
    end
    else if (wr_pins)
    begin
      pin_sel <= next_pin_sel;
    end
  end

  // ==========================================================================
  // Read path

  // Reserved bits are never stored, so they read back as zero.
  always_comb
  begin
    ctrl_word = adgc_pkg::RST_GENERAL_CONTROL;
    ctrl_word[adgc_pkg::BIT_BUFFER_PRECHARGE] = ctrl.buffer_precharge;
    ctrl_word[adgc_pkg::BIT_BUFFER_ENABLE]    = ctrl.buffer_enable;
    ctrl_word[adgc_pkg::BIT_CONFIG_LOCK]      = ctrl.config_lock;
    ctrl_word[adgc_pkg::BIT_BROADCAST_DAC]    = ctrl.broadcast_dac;
    ctrl_word[adgc_pkg::BIT_ADC_RANGE]        = ctrl.adc_range;
    ctrl_word[adgc_pkg::BIT_DAC_RANGE]        = ctrl.dac_range;
  end

  always_comb
  begin
    pin_word = adgc_pkg::RST_ANALOG_PIN_SEL;
    pin_word[adgc_pkg::PIN_SEL_LSB +: adgc_pkg::PIN_COUNT] = pin_sel;
  end

  assign rsel_word  = hit_ctrl ? ctrl_word : (hit_pins ? pin_word : '0);
  assign next_rdata = reg_rd ? rsel_word : '0;

  // Read data stand for exactly the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Buffer power policy

  // With precharge the buffer only burns power while a conversion runs.
  assign buf_power = ctrl.buffer_enable &&
                     (!ctrl.buffer_precharge || conv_active);
  assign buf_precharge_use = ctrl.buffer_enable && ctrl.buffer_precharge;

  // ==========================================================================
  // Range selects and pin configuration

  assign adc_range_2x      = ctrl.adc_range;
  assign dac_range_2x      = ctrl.dac_range;
  assign pin_config_lock   = ctrl.config_lock;
  assign analog_input_pins = pin_sel;
  assign pin_other_config  = ~pin_sel;

  // ==========================================================================
  // DAC write fan-out

  // The broadcast bit is sampled when the DAC write arrives, so a change
  // affects only later writes, never one already in flight.
  wire [adgc_pkg::PIN_COUNT-1:0] next_dac_load;

  genvar ch;
  generate
    for (ch = 0; ch < adgc_pkg::PIN_COUNT; ch++)
    begin : g_ch
      wire picked;
      assign picked = ctrl.broadcast_dac ? dac_pins[ch]
                    : (int'(dac_req.channel) == ch);
      assign next_dac_load[ch] = dac_req.valid && picked;
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_load      <= '0;
      dac_load_data <= '0;
    end
    else
    begin
      dac_load <= next_dac_load;
      if (dac_req.valid)
      begin
        dac_load_data <= dac_req.data;
      end
    end
  end

endmodule

// [tb/adgc_regs_asserts.sv]
`timescale 1ns/1ps
module adgc_regs_asserts
(
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // Register port
  input wire logic [3:0]              reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [15:0]             reg_rdata,
  // Converter and DAC side
  input wire logic                    conv_active,
  input wire adgc_pkg::adgc_dac_req_t dac_req,
  input wire logic [7:0]              dac_pins,
  input wire logic [7:0]              dac_load,
  input wire logic [11:0]             dac_load_data,
  // Controls
  input wire logic                    buf_power,
  input wire logic                    buf_precharge_use,
  input wire logic                    adc_range_2x,
  input wire logic                    dac_range_2x,
  input wire logic                    pin_config_lock,
  input wire logic [7:0]              analog_input_pins,
  input wire logic [7:0]              pin_other_config
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Properties
  sequence s_pin_wr;
    reg_wr && reg_addr == adgc_pkg::OFF_ANALOG_PIN_SEL;
  endsequence
  property p_ctrl_wr;
    reg_wr && reg_addr == adgc_pkg::OFF_GENERAL_CONTROL |=>
      {adc_range_2x, dac_range_2x, pin_config_lock} ==
      {$past(reg_wdata[5]), $past(reg_wdata[4]), $past(reg_wdata[7])};
  endproperty
  property p_ctrl_rd;
    reg_rd && reg_addr == 4'h3 |=> reg_rdata[15:10] == 6'h0 && reg_rdata[3:0] == 4'h0;
  endproperty
  property p_pin_rd;
    reg_rd && reg_addr == 4'h4 |=> reg_rdata[15:8] == 8'h00;
  endproperty
  property p_pin_wr;
    s_pin_wr ##0 !pin_config_lock |=> analog_input_pins == $past(reg_wdata[7:0]);
  endproperty
  property p_lock;
    s_pin_wr ##0 pin_config_lock |=> $stable(analog_input_pins);
  endproperty
  property p_other;
    pin_other_config == ~analog_input_pins;
  endproperty
  property p_prech;
    buf_precharge_use |-> buf_power == conv_active;
  endproperty
  property p_dac;
    dac_req.valid |=> dac_load_data == $past(dac_req.data) && (dac_load == $past(dac_pins)
      || dac_load == 8'h01 << $past(dac_req.channel));
  endproperty
  property p_dac_idle;
    !dac_req.valid |=> dac_load == 8'h00;
  endproperty
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control fields wrong");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control reserved bits set");
  a_pin_rd: assert property (p_pin_rd) else $error("pin reserved bits set");
  a_pin_wr: assert property (p_pin_wr) else $error("pin select not written");
  a_lock: assert property (p_lock) else $error("locked pin select changed");
  a_other: assert property (p_other) else $error("other config mismatch");
  a_prech: assert property (p_prech) else $error("precharge power wrong");
  a_dac: assert property (p_dac) else $error("dac load wrong");
  a_dac_idle: assert property (p_dac_idle) else $error("spurious dac load");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
endmodule

bind adgc_regs adgc_regs_asserts u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .conv_active, .dac_req, .dac_pins, .dac_load, .dac_load_data,
  .buf_power, .buf_precharge_use, .adc_range_2x, .dac_range_2x, .pin_config_lock,
  .analog_input_pins, .pin_other_config);

// [tb/adgc_host.sv]
`timescale 1ns/1ps
module adgc_host
(
  // Clock
  input  wire logic        clk,
  // Register port
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  // ==========================================================================
  // Bus cycles
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand for one cycle only, so they are taken just after the edge.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, conv_active, reg_wr, reg_rd, buf_power, buf_precharge_use;
  logic adc_range_2x, dac_range_2x, pin_config_lock;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rdv, ctrl, pins;
  logic [31:0] seed, r;
  logic [7:0] dac_pins, dac_load, analog_input_pins, pin_other_config;
  logic [11:0] dac_load_data;
  adgc_pkg::adgc_dac_req_t dac_req;
  int miscompares;
  int n_checks;
  adgc_host host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  adgc_regs uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv_active, .dac_req, .dac_pins, .dac_load, .dac_load_data, .buf_power,
    .buf_precharge_use, .adc_range_2x, .dac_range_2x, .pin_config_lock,
    .analog_input_pins, .pin_other_config);
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h8020_0003)};
    return seed;
  endfunction
  function automatic logic [7:0] exp_load(input logic [15:0] c, input logic [31:0] v);
    return c[6] ? v[31:24] : 8'h01 << v[14:12];
  endfunction
  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Stimulus
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {rst_n, conv_active, dac_pins, dac_req, ctrl, pins} = '0;
    {miscompares, n_checks} = '0;
    seed = 32'h0000_3bd9;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk(pin_other_config, 16'h00ff);
    host.rd(4'h3, rdv);
    chk(rdv, 16'h0000);
    host.rd(4'h4, rdv);
    chk(rdv, 16'h0000);
    host.wr(4'h9, 16'hffff);
    host.rd(4'h9, rdv);
    chk(rdv, 16'h0000);
    // Random lock values leave the pin select both frozen and open across the run.
    repeat (40)
    begin
      r = rnd();
      host.wr(4'h3, r[15:0]);
      ctrl = r[15:0] & 16'h03f0;
      r = rnd();
      host.wr(4'h4, r[15:0]);
      if (!ctrl[7])
        pins = r[15:0] & 16'h00ff;
      host.rd(4'h3, rdv);
      chk(rdv, ctrl);
      host.rd(4'h4, rdv);
      chk(rdv, pins);
      chk(analog_input_pins, pins);
      chk(pin_other_config, {8'h00, ~pins[7:0]});
      chk({adc_range_2x, dac_range_2x, pin_config_lock}, {ctrl[5], ctrl[4], ctrl[7]});
      r = rnd();
      @(posedge clk);
      conv_active <= r[20];
      dac_pins <= r[31:24];
      dac_req <= '{valid: 1'b1, channel: r[14:12], data: r[11:0]};
      @(posedge clk);
      dac_req.valid <= 1'b0;
      #1;
      chk(buf_power, ctrl[8] & (~ctrl[9] | r[20]));
      chk(buf_precharge_use, ctrl[8] & ctrl[9]);
      chk(dac_load, exp_load(ctrl, r));
      chk(dac_load_data, r[11:0]);
    end
    end_sim();
  end
endmodule
